// ---- inc/link_param_pkg.sv ----
// Constants, mode table and carriers for the link parameter and lane alignment configuration block
// =====================================================================
// How it works
// [RULE1] Every link parameter is derived from the single link mode selection field; the code takes 8B/10B K-1, DID and SCR from the control word.
// [RULE2] Lane rate equals sample clock times ratio R; R also sets serializer PLL factor.
// [RULE3] 8B/10B frames per multiframe come from the user field; 64B/66B ignores it.
// [RULE4] Multiblocks per extended multiblock is one in 64B/66B, ignored in 8B/10B.
// [RULE5] In 8B/10B every transport parameter goes out in the alignment sequence.
// [RULE6] 64B/66B sends no alignment sequence, yet both ends use same parameters.
// [RULE7] Adjustment amount and direction fields are sent as zero.
// [RULE8] Bank identifier and control words per frame are sent as zero.
// [RULE9] Control bits per sample is sent as zero in the alignment sequence.
// [RULE10] Link identifier sent equals the user-written device identifier.
// [RULE11] High density flag is sent as zero.
// [RULE12] Standard revision field always carries one.
// [RULE13] Subclass version field always carries one.
// [RULE14] Checksum is the sum of all preceding fields modulo 256.
// [RULE15] Octets per frame, lanes, resolution, samples per frame derive from mode.
// [RULE16] Converter count sets bit packing only; receiver deframes by it.
// [RULE17] Bits per sample after padding equals resolution plus control and tail bits.
// [RULE18] Each active lane gets its own lane identifier automatically.
// [RULE19] Lowest lanes are used, identifier equals index, higher lanes powered down.
// [RULE20] In 64B/66B frames per multiframe equals 8 times 32 times E over F.
// [RULE21] Checksum sums fields as encoded, using minus-one encodings where they apply.
package link_param_pkg;

   // =====================================================================
   // Sizes and fixed field values
   localparam int          NUM_LANES     = 8;
   localparam int          NUM_MODES     = 16;
   localparam logic [3:0]  JESDV_VALUE   = 4'h1;
   localparam logic [4:0]  SUBCLASS_VAL  = 5'h01;
   localparam logic [4:0]  E_VALUE       = 5'h01;
   localparam logic [10:0] K66_NUMER     = 11'h100;   // 8 x 32
   localparam logic [7:0]  ZERO8         = 8'h00;

   // =====================================================================
   // Wishbone register map (byte addresses)
   localparam logic [7:0]  CTRL_ADDR     = 8'h00;   // link mode, K-1, DID, SCR
   localparam logic [7:0]  PARAM_ADDR    = 8'h04;   // F-1, 8-bit K-1 (low 5 bits sent), M-1, L-1
   localparam logic [7:0]  PARAM2_ADDR   = 8'h08;   // N-1, N'-1, S-1, checksum
   localparam logic [7:0]  STATUS_ADDR   = 8'h0C;   // R x 32, lane enables, encoding
   localparam int          MODE_LSB      = 0;
   localparam int          KM1_LSB       = 8;
   localparam int          DID_LSB       = 16;
   localparam int          SCR_BIT       = 24;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_1F00;
   localparam logic [31:0] CTRL_MASK     = 32'h01FF_FF0F;

   // =====================================================================
   // Mode table entry; R held as a multiple of 1/32
   typedef struct packed {
      logic       enc66;
      logic [4:0] n;
      logic [3:0] l;
      logic [4:0] m;
      logic [4:0] f;
      logic [4:0] s;
      logic [1:0] cs;
      logic [1:0] e;
      logic [9:0] r32;
   } mode_entry_type;

   // Encoded alignment configuration octets
   typedef struct packed {
      logic [7:0] did;
      logic [3:0] adjcnt;
      logic [3:0] bid;
      logic       adjdir;
      logic       phadj;
      logic [4:0] lid;
      logic       scr;
      logic [4:0] lm1;
      logic [7:0] fm1;
      logic [4:0] km1;
      logic [7:0] mm1;
      logic [1:0] cs;
      logic [4:0] nm1;
      logic [2:0] subclassv;
      logic [4:0] npm1;
      logic [2:0] jesdv;
      logic [4:0] sm1;
      logic       hd;
      logic [4:0] cf;
      logic [7:0] res1;
      logic [7:0] res2;
   } ilas_cfg_type;

   typedef struct packed {
      logic [7:0] addr;
      logic       we;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;

   // Mode table lookup [RULE15] [RULE17] [RULE2]
   function automatic mode_entry_type mode_lookup(input logic [3:0] sel);
      mode_entry_type t;
      t = '0;
      case (sel)
         4'h0: t = '{1'b0, 5'd12, 4'd8, 5'd8, 5'd8, 5'd5, 2'd0, 2'd0, 10'd256};
         4'h1: t = '{1'b0, 5'd12, 4'd6, 5'd4, 5'd2, 5'd2, 2'd0, 2'd0, 10'd320};
         4'h2: t = '{1'b0, 5'd8,  4'd4, 5'd4, 5'd1, 5'd1, 2'd0, 2'd0, 10'd320};
         4'h3: t = '{1'b0, 5'd10, 4'd4, 5'd4, 5'd5, 5'd4, 2'd0, 2'd0, 10'd400};
         4'h4: t = '{1'b1, 5'd12, 4'd3, 5'd4, 5'd2, 5'd1, 2'd0, 2'd1, 10'd528};
         4'h5: t = '{1'b1, 5'd8,  4'd2, 5'd4, 5'd2, 5'd1, 2'd0, 2'd1, 10'd528};
         4'h6: t = '{1'b1, 5'd12, 4'd6, 5'd4, 5'd2, 5'd2, 2'd0, 2'd1, 10'd264};
         4'h7: t = '{1'b1, 5'd8,  4'd4, 5'd4, 5'd1, 5'd1, 2'd0, 2'd1, 10'd264};
         4'h8: t = '{1'b1, 5'd12, 4'd4, 5'd4, 5'd3, 5'd2, 2'd0, 2'd3, 10'd396};
         4'h9: t = '{1'b0, 5'd8,  4'd8, 5'd4, 5'd1, 5'd2, 2'd0, 2'd0, 10'd160};
         4'hA: t = '{1'b0, 5'd10, 4'd8, 5'd8, 5'd5, 5'd4, 2'd0, 2'd0, 10'd200};
         4'hB: t = '{1'b0, 5'd12, 4'd8, 5'd8, 5'd8, 5'd5, 2'd0, 2'd0, 10'd128};
         4'hC: t = '{1'b0, 5'd8,  4'd8, 5'd2, 5'd1, 5'd4, 2'd0, 2'd0, 10'd80};
         4'hD: t = '{1'b0, 5'd10, 4'd8, 5'd8, 5'd5, 5'd4, 2'd0, 2'd0, 10'd100};
         4'hE: t = '{1'b1, 5'd12, 4'd8, 5'd8, 5'd3, 5'd2, 2'd0, 2'd3, 10'd198};
         4'hF: t = '{1'b1, 5'd12, 4'd8, 5'd8, 5'd3, 5'd2, 2'd0, 2'd3, 10'd99};
         default: t = '0;
      endcase
      return t;
   endfunction : mode_lookup

endpackage : link_param_pkg

// ---- verilog/link_param_cfg.sv ----
// Link parameter derivation and lane alignment configuration with a Wishbone register port
`timescale 1ns/1ps
module link_param_cfg (
   // Clock and reset
   input  wire logic                        REF_CLK,
   input  wire logic                        RESET_N,
   // Wishbone slave
   input  wire logic                        WB_CYC_I,
   input  wire logic                        WB_STB_I,
   input  wire logic                        WB_WE_I,
   input  wire logic [7:0]                  WB_ADR_I,
   input  wire logic [3:0]                  WB_SEL_I,
   input  wire logic [31:0]                 WB_DAT_I,
   output logic      [31:0]                 WB_DAT_O,
   output logic                             WB_ACK_O,
   // Lane side
   output link_param_pkg::ilas_cfg_type     ILAS_CFG,
   output logic      [7:0]                  ILAS_CHKSUM,
   output logic      [7:0]                  LANE_EN,
   output logic      [39:0]                 LANE_ID,
   output logic                             ILAS_ENABLE,
   output logic                             ENC_64B66B,
   output logic      [9:0]                  RATE_R32,
   output logic      [8:0]                  FRAMES_PER_MF
);
   import link_param_pkg::*;

   // =====================================================================
   // Control register
   logic [31:0]    ctrl_reg;
   logic [31:0]    ctrl_next;
   logic           ack_reg;
   logic [31:0]    rdat_reg;
   logic [31:0]    rdat_next;
   wire  logic     wb_hit;
   wire  logic [31:0] wmask;

   assign wb_hit = WB_CYC_I & WB_STB_I & ~ack_reg;
   assign wmask  = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   // Only the control word is writable; other writes are acked and dropped
   assign ctrl_next = (wb_hit & WB_WE_I & (WB_ADR_I == CTRL_ADDR))
                      ? (((ctrl_reg & ~wmask) | (WB_DAT_I & wmask)) & CTRL_MASK) : ctrl_reg;

   // =====================================================================
   // Parameter derivation from the mode field [RULE1]; 8B/10B K-1, DID and SCR come from the control word
   wire  logic [3:0]   mode_sel;
   wire  logic [7:0]   km1_user;
   wire  mode_entry_type ent;
   wire  logic [10:0]  k66;
   wire  logic [8:0]   k_eff;
   wire  logic [7:0]   km1_eff;
   wire  ilas_cfg_type cfg;
   wire  logic [7:0]   sum;
   wire  logic [7:0]   lane_en_w;

   assign mode_sel = ctrl_reg[MODE_LSB +: 4];
   assign km1_user = ctrl_reg[KM1_LSB +: 8];
   assign ent      = mode_lookup(mode_sel);
   // E is fixed at one for 64B/66B [RULE4]; K derived as 256*E/F [RULE20]
   assign k66      = (ent.f == 5'd0) ? 11'h000 : 11'(K66_NUMER * 11'(E_VALUE) / 11'(ent.f));
   // User K only matters for 8B/10B [RULE3]
   assign k_eff    = ent.enc66 ? k66[8:0] : (9'(km1_user) + 9'h001);
   assign km1_eff  = 8'(k_eff - 9'h001);

   assign cfg.did       = ctrl_reg[DID_LSB +: 8];          // [RULE10]
   assign cfg.adjcnt    = 4'h0;                            // [RULE7]
   assign cfg.adjdir    = 1'b0;                            // [RULE7]
   assign cfg.phadj     = 1'b0;
   assign cfg.bid       = 4'h0;                            // [RULE8]
   assign cfg.cf        = 5'h00;                           // [RULE8]
   assign cfg.lid       = 5'h00;                           // Lane 0; per-lane IDs on LANE_ID [RULE18]
   assign cfg.scr       = ctrl_reg[SCR_BIT];
   assign cfg.lm1       = 5'(ent.l - 4'h1);                // [RULE21]
   assign cfg.fm1       = 8'(ent.f - 5'h01);               // [RULE21]
   assign cfg.km1       = km1_eff[4:0];
   assign cfg.mm1       = 8'(ent.m - 5'h01);               // Packing count, not channels [RULE16]
   assign cfg.cs        = 2'h0;                            // [RULE9]
   assign cfg.nm1       = 5'(ent.n - 5'h01);
   assign cfg.subclassv = SUBCLASS_VAL[2:0];               // [RULE13]
   assign cfg.npm1      = 5'(ent.n + 5'(ent.cs) - 5'h01);  // Tail bits are zero here [RULE17]
   assign cfg.jesdv     = JESDV_VALUE[2:0];                // [RULE12]
   assign cfg.sm1       = 5'(ent.s - 5'h01);
   assign cfg.hd        = 1'b0;                            // [RULE11]
   assign cfg.res1      = ZERO8;
   assign cfg.res2      = ZERO8;

   // Modulo-256 sum of the encoded fields; lane ID counts as lane 0 [RULE14] [RULE21]
   assign sum = 8'(cfg.did + cfg.adjcnt + cfg.bid + cfg.adjdir + cfg.phadj + cfg.lid + cfg.scr
                + cfg.lm1 + cfg.fm1 + cfg.km1 + cfg.mm1 + cfg.cs + cfg.nm1 + cfg.subclassv
                + cfg.npm1 + cfg.jesdv + cfg.sm1 + cfg.hd + cfg.cf);

   // Lowest lanes active, rest powered down [RULE19]
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LANES; gi++) begin : g_lane
         assign lane_en_w[gi] = (4'(gi) < ent.l);
      end
   endgenerate

   // =====================================================================
   // Read mux
   always_comb begin
      rdat_next = 32'h0000_0000;
      case (WB_ADR_I)
         CTRL_ADDR:   rdat_next = ctrl_reg;
         PARAM_ADDR:  rdat_next = {3'h0, cfg.lm1, cfg.mm1, km1_eff, cfg.fm1};
         PARAM2_ADDR: rdat_next = {sum, 3'h0, cfg.sm1, 3'h0, cfg.npm1, 3'h0, cfg.nm1};
         STATUS_ADDR: rdat_next = {13'h0000, ent.enc66, lane_en_w, ent.r32};
         default:     rdat_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_reg <= CTRL_RESET;
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         ack_reg  <= wb_hit;
         rdat_reg <= rdat_next;
      end
   end

   // =====================================================================
   // Registered outputs; one cycle behind a control write
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ILAS_CFG      <= '0;
         ILAS_CHKSUM   <= 8'h00;
         LANE_EN       <= 8'h00;
         LANE_ID       <= 40'h00_0000_0000;
         ILAS_ENABLE   <= 1'b0;
         ENC_64B66B    <= 1'b0;
         RATE_R32      <= 10'h000;
         FRAMES_PER_MF <= 9'h000;
      end else begin
         ILAS_CFG      <= cfg;                              // Both ends use the same set [RULE6]
         ILAS_CHKSUM   <= sum;                              // [RULE14]
         LANE_EN       <= lane_en_w;                        // [RULE19]
         LANE_ID       <= {5'd7, 5'd6, 5'd5, 5'd4, 5'd3, 5'd2, 5'd1, 5'd0};  // [RULE18]
         ILAS_ENABLE   <= ~ent.enc66;                       // [RULE5] [RULE6]
         ENC_64B66B    <= ent.enc66;
         RATE_R32      <= ent.r32;                          // Line rate = fs * R32 / 32 [RULE2]
         FRAMES_PER_MF <= k_eff;                            // [RULE3] [RULE20]
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdat_reg;

endmodule : link_param_cfg

// ---- test/jesd_rx_model.sv ----
// Receiver side model that rebuilds the alignment checksum from the received fields
`timescale 1ns/1ps
module jesd_rx_model (
   // Received configuration
   input  wire link_param_pkg::ilas_cfg_type cfg,
   input  wire logic [7:0]                   chksum,
   // Verdict
   output logic                              ok
);
   import link_param_pkg::*;
   wire logic [7:0] sum;
   // Field values are summed, not octets, so the lane id 0 carried here adds nothing
   assign sum = 8'(cfg.did + cfg.adjcnt + cfg.bid + cfg.adjdir + cfg.phadj + cfg.lid + cfg.scr + cfg.lm1 + cfg.fm1
                + cfg.km1 + cfg.mm1 + cfg.cs + cfg.nm1 + cfg.subclassv + cfg.npm1 + cfg.jesdv + cfg.sm1 + cfg.hd
                + cfg.cf + cfg.res1 + cfg.res2);
   assign ok = (sum == chksum);
endmodule : jesd_rx_model

// ---- test/link_param_cfg_sva.sv ----
// Concurrent checks on the ports of the link parameter block
`timescale 1ns/1ps
module link_param_cfg_sva (
   // Clock, reset and bus
   input wire logic                         REF_CLK,
   input wire logic                         RESET_N,
   input wire logic                         WB_CYC_I,
   input wire logic                         WB_STB_I,
   input wire logic                         WB_ACK_O,
   // Lane side
   input wire link_param_pkg::ilas_cfg_type ILAS_CFG,
   input wire logic [7:0]                   LANE_EN,
   input wire logic [39:0]                  LANE_ID,
   input wire logic                         ILAS_ENABLE,
   input wire logic                         ENC_64B66B,
   input wire logic [8:0]                   FRAMES_PER_MF
);
   import link_param_pkg::*;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   // =====================================================================
   // Settled flag: outputs hold reset values until the first edge after release
   logic up_reg;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) up_reg <= 1'b0;
      else up_reg <= 1'b1;
   end
   // =====================================================================
   // Assertions
   AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
   AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
   AST_ADJ_ZERO: assert property (ILAS_CFG.adjcnt == 4'h0 && !ILAS_CFG.adjdir) else $error("adj");
   AST_BID_CF: assert property (ILAS_CFG.bid == 4'h0 && ILAS_CFG.cf == 5'h00) else $error("bid cf");
   AST_CS_ZERO: assert property (ILAS_CFG.cs == 2'h0) else $error("cs");
   AST_HD_ZERO: assert property (ILAS_CFG.hd == 1'b0) else $error("hd");
   AST_FIXED: assert property (up_reg |-> ILAS_CFG.jesdv == 3'h1 && ILAS_CFG.subclassv == 3'h1)
      else $error("revision");
   AST_ILAS: assert property (up_reg |-> ILAS_ENABLE != ENC_64B66B) else $error("ilas enable");
   AST_LANE_ID: assert property (up_reg |-> LANE_ID == {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00})
      else $error("lane id");
   AST_LANE_EN: assert property (up_reg |-> LANE_EN == (8'hFF >> (5'h07 - ILAS_CFG.lm1))) else $error("lanes");
   AST_K66: assert property (ENC_64B66B |-> FRAMES_PER_MF == 9'(9'h100 / (ILAS_CFG.fm1 + 9'h001)))
      else $error("k");
   COV_ENC66: cover property (ENC_64B66B);
   COV_K256: cover property (ILAS_ENABLE && FRAMES_PER_MF == 9'h100);
   COV_ACK: cover property (WB_ACK_O);
endmodule : link_param_cfg_sva
bind link_param_cfg link_param_cfg_sva i_link_param_cfg_sva (.*);

// ---- test/testbench.sv ----
// Self-checking bench for the link parameter block
`timescale 1ns/1ps
module testbench;
   import link_param_pkg::*;
   logic         ref_clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]   adr = 8'h00;
   logic [3:0]   sel = 4'h0;
   logic [31:0]  dat_i = 32'h0, dat_o, q;
   logic         ack, ilas_en, enc66, ok;
   logic [7:0]   chksum, lane_en;
   logic [39:0]  lane_id;
   logic [9:0]   rate;
   logic [8:0]   fpm;
   ilas_cfg_type cfg;
   int           n_mismatch = 0, tests_run = 0;
   // =====================================================================
   // Expected mode table: lanes, converters, octets, resolution, samples, R x 32
   int lt[16] = '{8, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8, 8, 8, 8, 8, 8};
   int mt[16] = '{8, 4, 4, 4, 4, 4, 4, 4, 4, 4, 8, 8, 2, 8, 8, 8};
   int ft[16] = '{8, 2, 1, 5, 2, 2, 2, 1, 3, 1, 5, 8, 1, 5, 3, 3};
   int nt[16] = '{12, 12, 8, 10, 12, 8, 12, 8, 12, 8, 10, 12, 8, 10, 12, 12};
   int st[16] = '{5, 2, 1, 4, 1, 1, 2, 1, 2, 2, 4, 5, 4, 4, 2, 2};
   int rt[16] = '{256, 320, 320, 400, 528, 528, 264, 264, 396, 160, 200, 128, 80, 100, 198, 99};
   localparam logic [15:0] ENC_MASK = 16'hC1F0;
   always #5 ref_clk = ~ref_clk;
   link_param_cfg i_link_param_cfg (.REF_CLK(ref_clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .ILAS_CFG(cfg), .ILAS_CHKSUM(chksum), .LANE_EN(lane_en), .LANE_ID(lane_id), .ILAS_ENABLE(ilas_en),
      .ENC_64B66B(enc66), .RATE_R32(rate), .FRAMES_PER_MF(fpm));
   jesd_rx_model i_jesd_rx_model (.cfg(cfg), .chksum(chksum), .ok(ok));
   // =====================================================================
   // Shared tasks
   task automatic chk(input logic [79:0] got, input logic [79:0] want);
      tests_run++;
      if (got !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk
   // Entered at a rising edge; ack and read data are taken at the rising edge that samples ack high
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      {cyc, stb, we, adr, sel, dat_i} <= {2'b11, w, a, s, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) n_mismatch++;
      q = dat_o;
      {cyc, stb} <= 2'b00;
      @(posedge ref_clk);
   endtask : wb
   task automatic check_mode(input int m, input logic [7:0] k, input logic [7:0] d, input logic s);
      logic        e;
      logic [79:0] got, want;
      int          kx;
      logic [7:0]  ws;
      e = ENC_MASK[m];
      // Expected checksum from the tables: revision and subclass add one each, N' equals N
      kx = e ? 256 / ft[m] : int'(k) + 1;
      ws = 8'(int'(d) + lt[m] - 1 + ft[m] - 1 + ((kx - 1) & 31) + mt[m] - 1 + 2 * (nt[m] - 1) + st[m] - 1
              + 2 + int'(s));
      @(negedge ref_clk);
      got = {5'h00, cfg.lm1, cfg.mm1, cfg.fm1, cfg.nm1, cfg.npm1, cfg.sm1, cfg.did, cfg.scr, rate, lane_en, ilas_en,
             enc66, fpm, ok};
      want = {5'h00, 5'(lt[m] - 1), 8'(mt[m] - 1), 8'(ft[m] - 1), 5'(nt[m] - 1), 5'(nt[m] - 1), 5'(st[m] - 1), d, s,
              10'(rt[m]), 8'((1 << lt[m]) - 1), !e, e, e ? 9'(256 / ft[m]) : 9'(k + 9'h001), 1'b1};
      chk(got, want);
      chk(80'(chksum), 80'(ws));
      @(posedge ref_clk);
   endtask : check_mode
   // =====================================================================
   // Scenarios
   task automatic t_reset;
      reset_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      wb(1'b0, CTRL_ADDR, 4'hF, 32'h0);
      chk(80'(q), 80'(CTRL_RESET));
      check_mode(0, 8'h1F, 8'h00, 1'b0);
   endtask : t_reset
   // Every mode, with K-1 stepping down from its top value
   task automatic t_modes;
      logic [7:0] k;
      for (int m = 0; m < 16; m++) begin
         k = 8'(8'hFF - m * 16);
         wb(1'b1, CTRL_ADDR, 4'hF, {7'h00, m[0], 8'(m * 17), k, 4'h0, 4'(m)});
         check_mode(m, k, 8'(m * 17), m[0]);
      end
   endtask : t_modes
   task automatic t_bus;
      wb(1'b1, CTRL_ADDR, 4'h4, 32'h1234_5678);
      wb(1'b1, PARAM_ADDR, 4'hF, 32'hFFFF_FFFF);
      wb(1'b0, CTRL_ADDR, 4'hF, 32'h0);
      chk(80'(q), 80'(32'h0134_0F0F));
      wb(1'b0, 8'h10, 4'hF, 32'h0);
      chk(80'(q), 80'h0);
      check_mode(15, 8'h0F, 8'h34, 1'b1);
   endtask : t_bus
   task automatic test_done;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   initial begin
      t_reset;
      t_modes;
      t_bus;
      t_reset;
      test_done;
   end
   initial begin
      #20000;
      n_mismatch++;
      test_done;
   end
endmodule : testbench
